/* verilog/sprc_pkg.sv */
package sprc_pkg;
   // Register addresses on the special-function bus
   localparam logic [7:0] ADDR_P1_DATA  = 8'h90;
   localparam logic [7:0] ADDR_PORT1_DIRECTION   = 8'h96;
   localparam logic [7:0] ADDR_P1_FUNC  = 8'h97;
   localparam logic [7:0] ADDR_RADIO    = 8'hA0;
   localparam logic [7:0] ADDR_ROUTE    = 8'hB3;
   // Reset values
   localparam logic [3:0] RST_P1_DATA   = 4'hF;
   localparam logic [3:0] RST_PORT1_DIRECTION    = 4'h4;
   localparam logic [3:0] RST_P1_FUNC   = 4'h0;
   localparam logic [7:0] RST_RADIO     = 8'h08;
   // Port comes up as an SPI master port, so the selector resets to that route
   localparam logic [1:0] RST_ROUTE     = 2'h1;
   // Route selector codes
   localparam logic [1:0] ROUTE_NONE    = 2'h0;
   localparam logic [1:0] ROUTE_PORT1   = 2'h1;
   // Port-1 bit positions
   localparam int P1_SCK_BIT   = 0;
   localparam int P1_MOSI_BIT  = 1;
   localparam int P1_MISO_BIT  = 2;
   localparam int P1_BOOT_BIT  = 3;
   // Radio port write bit positions
   localparam int RW_ENABLE_BIT = 5;
   localparam int RW_TXSEL_BIT  = 4;
   localparam int RW_SEL_BIT    = 3;
   localparam int RW_DIN_BIT    = 1;
   localparam int RW_CLK_BIT    = 0;
   localparam logic [7:0] RADIO_WR_MASK = 8'h3B;
   // Timer-2 input sample period in CPU clocks
   localparam int T2_SAMPLE_CYCLES = 4;

   typedef struct packed {
      logic enable;
      logic tx_select;
      logic serial_select;
      logic serial_data_in;
      logic serial_clock;
   } sprc_radio_ctrl_t;

   typedef struct packed {
      logic address_match;
      logic carrier_sense;
      logic packet_ready;
      logic adc_done;
      logic serial_data_out;
   } sprc_radio_stat_t;
endpackage : sprc_pkg

/* verilog/sprc_mux.sv */
`timescale 1ns/1ps
// Behaviour
// - Route 01: SCK, MOSI drive out, MISO input, boot select general output.
// - Function bit 0 makes SCK the timer-2 input, sampled every 4 clocks.
// - Otherwise plain GPIO, direction bit 0 output, 1 input.
// - Direction ignored when alternate function selected or route is 01.
// - MISO pin is always an input.
// - Bits 1 and 3 have no alternate function; direction bit rules.
// - Boot select pin is always GPIO; loader drives it to select boot flash.
// - Port-1 data, direction, function registers hold only 4 low bits.
// - Port 1 resets as SPI master port; selector reset taken as 01.
// - Route 00 unused, 01 port 1, 1x radio subsystem.
// - Radio port read: 7 match, 6 carrier, 5 ready, 4 ADC, 2 data out.
// - Radio port write: 5 enable, 4 tx select, 3 select, 1 data in, 0 clock.
// - Radio latch resets to 0x08: select high, others low.
// - Route 1x lets the SPI master override some radio bits.
// - Radio port is one-way: written bits out, read bits in.
// - Route 0x wires every radio line straight to its latch bit.
// - Reset forces radio outputs to defaults until software writes.
module sprc_mux #(
   parameter int P1_WIDTH = 4
) (
   input  wire logic                      clk_in,        // CPU clock
   input  wire logic                      reset_n_in,    // Async reset, low
   input  wire logic                      ce_in,         // Clock enable
   input  wire logic [7:0]                sfr_addr_in,   // Register address
   input  wire logic                      sfr_wr_in,     // Write strobe
   input  wire logic [7:0]                sfr_wdata_in,  // Write data
   output logic [7:0]                     sfr_rdata_out, // Read data, 1 cycle late
   input  wire logic [P1_WIDTH-1:0]       p1_pin_in,     // Port-1 pin levels
   output logic [P1_WIDTH-1:0]            p1_pin_out,    // Port-1 drive values
   output logic [P1_WIDTH-1:0]            p1_pin_oe_n_out, // Low while driving
   input  wire logic                      spi_sck_in,    // SPI master clock
   input  wire logic                      spi_mosi_in,   // SPI master data out
   output logic                           spi_miso_out,  // SPI master data in
   output logic                           timer2_count_out, // Sampled timer-2 input
   input  wire sprc_pkg::sprc_radio_stat_t radio_stat_in, // Radio status lines
   output sprc_pkg::sprc_radio_ctrl_t      radio_ctrl_out // Radio control lines
);
   typedef struct packed {
      logic [P1_WIDTH-1:0]        p1_data;
      logic [P1_WIDTH-1:0]        port1_direction;
      logic [P1_WIDTH-1:0]        p1_func;
      logic [1:0]                 route;
      logic [7:0]                 radio;
      logic [P1_WIDTH-1:0]        pin_s1;
      logic [P1_WIDTH-1:0]        pin_s2;
      sprc_pkg::sprc_radio_stat_t stat_s1;
      sprc_pkg::sprc_radio_stat_t stat_s2;
      logic [1:0]                 t2_div;
      logic                       t2;
      logic [7:0]                 rdata;
      logic [P1_WIDTH-1:0]        pout;
      logic [P1_WIDTH-1:0]        poe_n;
      logic                       miso;
      sprc_pkg::sprc_radio_ctrl_t rctl;
   } sprc_state_t;

   localparam sprc_state_t RESET_STATE = '{
      p1_data: P1_WIDTH'(sprc_pkg::RST_P1_DATA),
      port1_direction:  P1_WIDTH'(sprc_pkg::RST_PORT1_DIRECTION),
      p1_func: P1_WIDTH'(sprc_pkg::RST_P1_FUNC),
      route:   sprc_pkg::RST_ROUTE,
      radio:   sprc_pkg::RST_RADIO,
      pin_s1:  '0,
      pin_s2:  '0,
      stat_s1: '0,
      stat_s2: '0,
      t2_div:  2'h0,
      t2:      1'b0,
      rdata:   8'h00,
      pout:    P1_WIDTH'(sprc_pkg::RST_P1_DATA),
      // Boot route drives clock, data out and select; only MISO floats
      poe_n:   P1_WIDTH'(4'h4),
      miso:    1'b0,
      rctl:    '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0}
   };

   sprc_state_t q;
   sprc_state_t d;
   logic        route_p1;
   logic        route_radio;
   logic [7:0]  stat_byte;

   always_comb begin
      route_p1    = (q.route == sprc_pkg::ROUTE_PORT1);
      route_radio = q.route[1];
      // Only the status lines appear, unused bits read 0
      stat_byte = 8'h00;
      stat_byte[7] = q.stat_s2.address_match;
      stat_byte[6] = q.stat_s2.carrier_sense;
      stat_byte[5] = q.stat_s2.packet_ready;
      stat_byte[4] = q.stat_s2.adc_done;
      stat_byte[2] = q.stat_s2.serial_data_out;
      d = q;
      d.pin_s1  = p1_pin_in;
      d.pin_s2  = q.pin_s1;
      d.stat_s1 = radio_stat_in;
      d.stat_s2 = q.stat_s1;
      if (sfr_wr_in) begin
         case (sfr_addr_in)
            sprc_pkg::ADDR_P1_DATA: d.p1_data = sfr_wdata_in[P1_WIDTH-1:0];
            sprc_pkg::ADDR_PORT1_DIRECTION:  d.port1_direction  = sfr_wdata_in[P1_WIDTH-1:0];
            sprc_pkg::ADDR_P1_FUNC: d.p1_func = sfr_wdata_in[P1_WIDTH-1:0];
            sprc_pkg::ADDR_RADIO:
               d.radio = sfr_wdata_in & sprc_pkg::RADIO_WR_MASK;
            sprc_pkg::ADDR_ROUTE:   d.route   = sfr_wdata_in[1:0];
            default: ;
         endcase
      end
      // Read data registered: address in cycle 0, data valid in cycle 1
      case (sfr_addr_in)
         sprc_pkg::ADDR_P1_DATA: d.rdata = {{(8-P1_WIDTH){1'b0}}, q.pin_s2};
         sprc_pkg::ADDR_PORT1_DIRECTION:  d.rdata = {{(8-P1_WIDTH){1'b0}}, q.port1_direction};
         sprc_pkg::ADDR_P1_FUNC: d.rdata = {{(8-P1_WIDTH){1'b0}}, q.p1_func};
         sprc_pkg::ADDR_RADIO:   d.rdata = stat_byte;
         sprc_pkg::ADDR_ROUTE:   d.rdata = {6'h00, q.route};
         default:                d.rdata = 8'h00;
      endcase
      // Per-bit pin direction
      for (int i = 0; i < P1_WIDTH; i++) begin
         d.pout[i]  = q.p1_data[i];
         d.poe_n[i] = q.port1_direction[i];
         if (route_p1) begin
            d.poe_n[i] = 1'b0;
         end else if (i == sprc_pkg::P1_SCK_BIT && q.p1_func[i]) begin
            d.poe_n[i] = 1'b1;
         end
         if (i == sprc_pkg::P1_MISO_BIT) begin
            d.poe_n[i] = 1'b1;
         end
      end
      if (route_p1) begin
         d.pout[sprc_pkg::P1_SCK_BIT]  = spi_sck_in;
         d.pout[sprc_pkg::P1_MOSI_BIT] = spi_mosi_in;
      end
      // Timer-2 input sampled on every fourth clock only
      d.t2_div = q.t2_div + 2'h1;
      if (q.t2_div == 2'(sprc_pkg::T2_SAMPLE_CYCLES - 1) && !route_p1
          && q.p1_func[sprc_pkg::P1_SCK_BIT]) begin
         d.t2 = q.pin_s2[sprc_pkg::P1_SCK_BIT];
      end
      // Radio control lines straight from the latch unless overridden
      d.rctl.enable         = q.radio[sprc_pkg::RW_ENABLE_BIT];
      d.rctl.tx_select      = q.radio[sprc_pkg::RW_TXSEL_BIT];
      d.rctl.serial_select  = q.radio[sprc_pkg::RW_SEL_BIT];
      d.rctl.serial_data_in = q.radio[sprc_pkg::RW_DIN_BIT];
      d.rctl.serial_clock   = q.radio[sprc_pkg::RW_CLK_BIT];
      d.miso = 1'b0;
      if (route_radio) begin
         d.rctl.serial_data_in = spi_mosi_in;
         d.rctl.serial_clock   = spi_sck_in;
         d.miso = q.stat_s2.serial_data_out;
      end else if (route_p1) begin
         d.miso = q.pin_s2[sprc_pkg::P1_MISO_BIT];
      end
      if (!ce_in) begin
         d = q;
      end
   end

   // Async reset puts the radio lines at default with or without a clock
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign sfr_rdata_out    = q.rdata;
   assign p1_pin_out       = q.pout;
   assign p1_pin_oe_n_out  = q.poe_n;
   assign spi_miso_out     = q.miso;
   assign timer2_count_out = q.t2;
   assign radio_ctrl_out   = q.rctl;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   a_miso_always_in: assert property (p1_pin_oe_n_out[sprc_pkg::P1_MISO_BIT])
      else $error("MISO pin driven");
   a_spi_route_pins: assert property (ce_in && q.route == 2'h1 |=>
      !p1_pin_oe_n_out[0] && !p1_pin_oe_n_out[1] && !p1_pin_oe_n_out[3]
      && p1_pin_out[0] == $past(spi_sck_in))
      else $error("SPI route pins wrong");
   a_gpio_dir_follow: assert property (ce_in && q.route != 2'h1 |=>
      p1_pin_oe_n_out[1] == $past(q.port1_direction[1])
      && p1_pin_oe_n_out[3] == $past(q.port1_direction[3]))
      else $error("GPIO direction wrong");
   a_t2_pin_input: assert property (ce_in && q.route != 2'h1 && q.p1_func[0] |=>
      p1_pin_oe_n_out[0])
      else $error("Timer pin driven");
   a_t2_sample_rate: assert property (ce_in && q.t2_div != 2'h3 |=> $stable(q.t2))
      else $error("Timer input sampled off period");
   a_radio_bang: assert property (ce_in && !q.route[1] |=>
      radio_ctrl_out.serial_clock == $past(q.radio[0])
      && radio_ctrl_out.serial_data_in == $past(q.radio[1]))
      else $error("Radio line not from latch");
   a_radio_spi_ovr: assert property (ce_in && q.route[1] |=>
      radio_ctrl_out.serial_clock == $past(spi_sck_in)
      && radio_ctrl_out.serial_select == $past(q.radio[3]))
      else $error("Radio override wrong");
   a_radio_read_map: assert property (ce_in && sfr_addr_in == 8'hA0 |=>
      sfr_rdata_out[3] == 1'b0 && sfr_rdata_out[1:0] == 2'h0
      && sfr_rdata_out[7] == $past(q.stat_s2.address_match))
      else $error("Radio read map wrong");
   a_port_read_high: assert property (ce_in && (sfr_addr_in == sprc_pkg::ADDR_P1_DATA
      || sfr_addr_in == sprc_pkg::ADDR_PORT1_DIRECTION || sfr_addr_in == sprc_pkg::ADDR_P1_FUNC)
      |=> sfr_rdata_out[7:P1_WIDTH] == '0)
      else $error("Port register upper bits not zero");
   a_port_dir_write: assert property (ce_in && sfr_wr_in
      && sfr_addr_in == sprc_pkg::ADDR_PORT1_DIRECTION
      |=> q.port1_direction == $past(sfr_wdata_in[P1_WIDTH-1:0]))
      else $error("Direction write wrong");
   a_route_read_back: assert property (ce_in && sfr_addr_in == sprc_pkg::ADDR_ROUTE
      |=> sfr_rdata_out == {6'h00, $past(q.route)})
      else $error("Route read wrong");
   a_reset_radio: assert property ($rose(reset_n_in) |->
      radio_ctrl_out.serial_select && !radio_ctrl_out.enable)
      else $error("Radio default wrong");

   // Port-1 pin routing
   a_reset_port_oe: assert property ($rose(reset_n_in)
      |-> p1_pin_oe_n_out == P1_WIDTH'(4'h4)
      && q.route == sprc_pkg::ROUTE_PORT1)
      else $error("Port not SPI master after reset");
   a_boot_sel_data: assert property (ce_in && q.route == sprc_pkg::ROUTE_PORT1
      |=> p1_pin_out[sprc_pkg::P1_BOOT_BIT]
      == $past(q.p1_data[sprc_pkg::P1_BOOT_BIT]))
      else $error("Boot select not from latch");
   a_gpio_data_out: assert property (ce_in && q.route != sprc_pkg::ROUTE_PORT1
      |=> p1_pin_out == $past(q.p1_data))
      else $error("GPIO data wrong");
   a_mosi_gpio_only: assert property (ce_in && q.route != sprc_pkg::ROUTE_PORT1
      && q.p1_func[sprc_pkg::P1_MOSI_BIT]
      |=> p1_pin_oe_n_out[sprc_pkg::P1_MOSI_BIT] == $past(q.port1_direction[sprc_pkg::P1_MOSI_BIT]))
      else $error("Data pin left direction control");
   a_sck_gpio_dir: assert property (ce_in && q.route != sprc_pkg::ROUTE_PORT1
      && !q.p1_func[sprc_pkg::P1_SCK_BIT]
      |=> p1_pin_oe_n_out[sprc_pkg::P1_SCK_BIT] == $past(q.port1_direction[sprc_pkg::P1_SCK_BIT]))
      else $error("Clock pin direction wrong");

   // Data returned to the SPI master
   a_miso_from_pin: assert property (ce_in && q.route == sprc_pkg::ROUTE_PORT1
      |=> spi_miso_out == $past(q.pin_s2[sprc_pkg::P1_MISO_BIT]))
      else $error("SPI data in not from port");
   a_miso_idle_zero: assert property (ce_in && q.route == sprc_pkg::ROUTE_NONE
      |=> !spi_miso_out)
      else $error("SPI data in not idle");
   a_miso_radio_data: assert property (ce_in && q.route[1]
      |=> spi_miso_out == $past(q.stat_s2.serial_data_out))
      else $error("SPI data in not from radio");

   // Timer input sampling
   a_t2_hold_spi: assert property (ce_in && q.route == sprc_pkg::ROUTE_PORT1
      |=> $stable(q.t2))
      else $error("Timer input sampled on SPI route");
   a_t2_sample_pin: assert property (ce_in && q.t2_div == 2'h3
      && q.route != sprc_pkg::ROUTE_PORT1 && q.p1_func[sprc_pkg::P1_SCK_BIT]
      |=> timer2_count_out == $past(q.pin_s2[sprc_pkg::P1_SCK_BIT]))
      else $error("Timer input sample wrong");

   // Radio port
   a_radio_wr_mask: assert property (ce_in && sfr_wr_in
      && sfr_addr_in == sprc_pkg::ADDR_RADIO
      |=> q.radio == ($past(sfr_wdata_in) & sprc_pkg::RADIO_WR_MASK))
      else $error("Radio latch write wrong");
   a_radio_enable_sw: assert property (ce_in && q.route[1]
      |=> radio_ctrl_out.enable == $past(q.radio[sprc_pkg::RW_ENABLE_BIT])
      && radio_ctrl_out.tx_select == $past(q.radio[sprc_pkg::RW_TXSEL_BIT]))
      else $error("Radio enable not from latch");
   a_radio_sel_bang: assert property (ce_in && !q.route[1]
      |=> radio_ctrl_out.serial_select == $past(q.radio[sprc_pkg::RW_SEL_BIT])
      && radio_ctrl_out.enable == $past(q.radio[sprc_pkg::RW_ENABLE_BIT]))
      else $error("Radio select not from latch");
   a_radio_din_ovr: assert property (ce_in && q.route[1]
      |=> radio_ctrl_out.serial_data_in == $past(spi_mosi_in))
      else $error("Radio data in not from SPI");

   c_spi_port1: cover property (q.route == 2'h1 && !p1_pin_oe_n_out[0]);
   c_spi_radio: cover property (q.route[1] && radio_ctrl_out.serial_clock);
   c_t2_sample: cover property (q.p1_func[0] && $changed(q.t2));
   c_radio_wr:  cover property (sfr_wr_in && sfr_addr_in == 8'hA0);
   c_ce_freeze: cover property (!ce_in && sfr_wr_in);
endmodule : sprc_mux

/* tb/sprc_partner.sv */
`timescale 1ns/1ps
module sprc_partner (
   input  wire logic                       clk_in,     // CPU clock
   input  wire sprc_pkg::sprc_radio_ctrl_t ctrl_in,    // Radio control lines
   input  wire logic [3:0]                 flags_in,   // Wanted status flags
   input  wire logic [3:0]                 p1_in,      // Device drive values
   input  wire logic [3:0]                 p1_oe_n_in, // Low while device drives
   input  wire logic [3:0]                 ext_in,     // Other board drivers
   output sprc_pkg::sprc_radio_stat_t      stat_out,   // Radio status lines
   output logic [3:0]                      wire_out    // Resolved pin levels
);
   logic rad_q = 1'b0;
   logic mem_q = 1'b0;
   logic sck_q = 1'b0;
   // Released data lines wander, so a stale value never passes
   always @(posedge clk_in) begin
      sck_q <= ctrl_in.serial_clock;
      if (ctrl_in.serial_select) rad_q <= ~rad_q;
      else if (ctrl_in.serial_clock && !sck_q) rad_q <= ~ctrl_in.serial_data_in;
      mem_q <= wire_out[3] ? ~mem_q : ~wire_out[1];
   end
   assign stat_out = {flags_in, rad_q};
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wire_out[i] = !p1_oe_n_in[i] ? p1_in[i] : (i == 2) ? mem_q : ext_in[i];
      end
   end
endmodule : sprc_partner

/* tb/tb_serial_port_and_radio_ctrl_mux.sv */
`timescale 1ns/1ps
module tb_serial_port_and_radio_ctrl_mux;
   logic                       clk_in = 1'b0;
   logic                       reset_n_in = 1'b0;
   logic [7:0]                 addr = 8'h00;
   logic                       wr = 1'b0;
   logic [7:0]                 wdata = 8'h00;
   logic [7:0]                 rdata;
   logic [3:0]                 p_out, p_oe_n, p_wire, e;
   logic [3:0]                 ext = 4'h0;
   logic [3:0]                 flags = 4'h0;
   logic                       sck = 1'b0;
   logic                       mosi = 1'b0;
   logic                       ce = 1'b1;
   logic                       miso, t2;
   sprc_pkg::sprc_radio_stat_t stat;
   sprc_pkg::sprc_radio_ctrl_t ctrl;
   int                         fail_count = 0;
   int                         checked = 0;
   logic [7:0]                 m_data = 8'h0F, m_dir = 8'h04, m_func = 8'h00, v;
   const logic [7:0]           ra [4] = '{8'h96, 8'h97, 8'hB3, 8'h55};
   const logic [7:0]           re [4] = '{8'h04, 8'h00, 8'h01, 8'h00};
   sprc_mux dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce), .sfr_addr_in(addr),
      .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .p1_pin_in(p_wire),
      .p1_pin_out(p_out), .p1_pin_oe_n_out(p_oe_n), .spi_sck_in(sck), .spi_mosi_in(mosi),
      .spi_miso_out(miso), .timer2_count_out(t2), .radio_stat_in(stat), .radio_ctrl_out(ctrl));
   sprc_partner partner (.clk_in(clk_in), .ctrl_in(ctrl), .flags_in(flags), .p1_in(p_out),
      .p1_oe_n_in(p_oe_n), .ext_in(ext), .stat_out(stat), .wire_out(p_wire));
   initial forever #5 clk_in = ~clk_in;
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wr <= 1'b1;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
      if (a == sprc_pkg::ADDR_P1_DATA) m_data = d & 8'h0F;
      if (a == sprc_pkg::ADDR_PORT1_DIRECTION) m_dir = d & 8'h0F;
      if (a == sprc_pkg::ADDR_P1_FUNC) m_func = d & 8'h0F;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      @(posedge clk_in);
      #1 d = rdata;
   endtask : rd_reg
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : settle
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      fail_count++;
      final_report;
   end
   initial begin
      void'($urandom(98));
      settle(2);
      chk("reset oe_n", 8'h04, {4'h0, p_oe_n});
      chk("reset ctrl", 8'h04, {3'h0, ctrl});
      @(posedge clk_in);
      reset_n_in <= 1'b1;
      wr_reg(8'h55, 8'hFF);
      foreach (ra[i]) begin
         rd_reg(ra[i], v);
         chk("reset reg", re[i], v);
      end
      wr_reg(sprc_pkg::ADDR_P1_DATA, 8'h00);
      wr_reg(sprc_pkg::ADDR_PORT1_DIRECTION, 8'($urandom));
      repeat (4) begin
         @(posedge clk_in);
         sck <= 1'($urandom);
         mosi <= 1'($urandom);
         settle(5);
         chk("spi oe_n", 8'h04, {4'h0, p_oe_n});
         chk("spi pins", {4'h0, m_data[3], 1'b0, mosi, sck}, {4'h0, p_out & 4'hB});
         chk("spi miso", {7'h0, ~mosi}, {7'h0, miso});
      end
      wr_reg(sprc_pkg::ADDR_ROUTE, 8'h00);
      repeat (6) begin
         wr_reg(sprc_pkg::ADDR_P1_DATA, 8'($urandom));
         wr_reg(sprc_pkg::ADDR_PORT1_DIRECTION, 8'($urandom));
         wr_reg(sprc_pkg::ADDR_P1_FUNC, 8'($urandom));
         settle(2);
         e = m_dir[3:0] | 4'h4 | {3'h0, m_func[0]};
         chk("gpio oe_n", {4'h0, e}, {4'h0, p_oe_n});
         chk("gpio out", {4'h0, m_data[3:0] & ~e}, {4'h0, p_out & ~e});
         chk("gpio miso", 8'h00, {7'h0, miso});
      end
      rd_reg(sprc_pkg::ADDR_P1_FUNC, v);
      chk("func", m_func, v);
      repeat (4) begin
         @(posedge clk_in);
         flags <= 4'($urandom);
         v = 8'($urandom);
         wr_reg(sprc_pkg::ADDR_RADIO, v);
         settle(2);
         chk("ctrl", {3'h0, v[5:3], v[1:0]}, {3'h0, ctrl});
         rd_reg(sprc_pkg::ADDR_RADIO, v);
         chk("status", {flags, 4'h0}, v & 8'hFB);
      end
      wr_reg(sprc_pkg::ADDR_RADIO, 8'h30);
      for (int r = 2; r < 4; r++) begin
         wr_reg(sprc_pkg::ADDR_ROUTE, 8'(r));
         repeat (2) begin
            @(posedge clk_in);
            mosi <= 1'($urandom);
            sck <= 1'b1;
            settle(2);
            chk("rad ctrl", {3'h0, 3'b110, mosi, 1'b1}, {3'h0, ctrl});
            @(posedge clk_in);
            sck <= 1'b0;
            settle(5);
            chk("rad miso", {7'h0, ~mosi}, {7'h0, miso});
         end
      end
      wr_reg(sprc_pkg::ADDR_ROUTE, 8'h00);
      wr_reg(sprc_pkg::ADDR_P1_FUNC, 8'h01);
      wr_reg(sprc_pkg::ADDR_PORT1_DIRECTION, 8'h0F);
      // Link clock runs only within the frame, then rests
      for (int j = 7; j < 10; j += 2) begin
         repeat (j) #62.5 ext[0] = ~ext[0];
         settle(12);
         chk("timer2", {7'h0, ext[0]}, {7'h0, t2});
      end
      @(posedge clk_in);
      ce <= 1'b0;
      wr_reg(sprc_pkg::ADDR_RADIO, 8'h3B);
      settle(2);
      chk("ce ctrl", 8'h18, {3'h0, ctrl});
      @(posedge clk_in);
      ce <= 1'b1;
      settle(2);
      chk("ce keep", 8'h18, {3'h0, ctrl});
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      #3;
      chk("rerst oe_n", 8'h04, {4'h0, p_oe_n});
      chk("rerst ctrl", 8'h04, {3'h0, ctrl});
      final_report;
   end
endmodule : tb_serial_port_and_radio_ctrl_mux
